/* File: common/sar_adc_pkg.sv */
`default_nettype none
package sar_adc_pkg;

	// converter word geometry
	localparam int WORD_W = 10;
	localparam int TRIAL_W = 4;
	localparam logic [TRIAL_W-1:0] MSB_IDX = 4'h9;
	localparam logic [TRIAL_W-1:0] LSB_IDX = 4'h0;
	localparam logic [TRIAL_W-1:0] TRIAL_ONE = 4'h1;
	localparam logic [TRIAL_W-1:0] TRIAL_ZERO = 4'h0;
	localparam logic [TRIAL_W-1:0] STEP_COUNT = 4'hA;
	localparam logic [WORD_W-1:0] WORD_ONE = 10'h001;

	// drive pattern after a clear: msb switch on, all others off
	localparam logic [WORD_W-1:0] CLEAR_DRIVE = 10'h1FF;
	// result pattern after a clear: one followed by nine zeros
	localparam logic [WORD_W-1:0] CLEAR_WORD = 10'h200;

	// external pins, grouped for synchronising
	typedef struct packed {
		logic demand;
		logic clear;
		logic shift;
		logic comp;
	} pins_t;

	localparam pins_t PINS_ZERO = '{demand: 1'b0, clear: 1'b0, shift: 1'b0, comp: 1'b0};

	// three-stage synchroniser state
	typedef struct packed {
		pins_t s1;
		pins_t s2;
		pins_t s3;
		pins_t lvl;
	} sync_state_t;

	// rising-edge detector state
	typedef struct packed {
		pins_t prev;
		pins_t rise;
	} edge_state_t;

	// conversion phases
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_CONVERT,
		PH_DONE
	} phase_t;

	// sequencer state
	typedef struct packed {
		phase_t phase;
		logic [TRIAL_W-1:0] trial;
		logic [WORD_W-1:0] drive;
		logic [WORD_W-1:0] word;
		logic ready;
	} sar_state_t;

	localparam sar_state_t SAR_RESET = '{
		phase: PH_IDLE,
		trial: MSB_IDX,
		drive: CLEAR_DRIVE,
		word: CLEAR_WORD,
		ready: 1'b0
	};

endpackage : sar_adc_pkg
`default_nettype wire

/* File: rtl/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_sync
	import sar_adc_pkg::*;
(
	// clock, reset and enable
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// raw pins and filtered levels
	input var pins_t pins_raw,
	output var pins_t pins_lvl
);

	sync_state_t st_reg;
	sync_state_t st_next;

	// shift chain; level follows only when stages two and three agree
	always_comb begin
		st_next = st_reg;
		st_next.s1 = pins_raw;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		for (int i = 0; i < $bits(pins_t); i++) begin
			if (st_reg.s2[i] == st_reg.s3[i]) begin
				st_next.lvl[i] = st_reg.s3[i];
			end
		end
	end

	// state register
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '{s1: PINS_ZERO, s2: PINS_ZERO, s3: PINS_ZERO, lvl: PINS_ZERO};
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	assign pins_lvl = st_reg.lvl;

endmodule : pin_sync
`default_nettype wire

/* File: rtl/pin_edge.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_edge
	import sar_adc_pkg::*;
(
	// clock, reset and enable
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// filtered levels and their rising edges
	input var pins_t pins_lvl,
	output var pins_t pins_rise
);

	edge_state_t st_reg;
	edge_state_t st_next;

	// one-cycle pulse on each rising level
	always_comb begin
		st_next.prev = pins_lvl;
		st_next.rise = pins_lvl & ~st_reg.prev;
	end

	// state register
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= '{prev: PINS_ZERO, rise: PINS_ZERO};
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	assign pins_rise = st_reg.rise;

endmodule : pin_edge
`default_nettype wire

/* File: rtl/sar_adc_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RQ1: a conversion starts at the msb and tries a zero on one bit at a time, downward.
// RQ2: each switch-drive bit is active low, zero closes its ladder switch.
// RQ3: if the ladder level is above the input, the tried bit goes back to one.
// RQ4: if the input is above the ladder level, the tried bit stays at zero.
// RQ5: trials go on until the lsb is decided, and then the word is complete.
// RQ6: the output word is the bitwise complement of the switch-drive bits.
// RQ7: register and output word are ten bits wide.
// RQ8: a comparator one means the input is above the ladder, zero means below.
// RQ9: the clear pulse after the demand edge clears all conversion state.
// RQ10: after a clear, bit 9 (msb) drive is zero and the rest are one.
// RQ11: each step resolves the tried bit, tries the next, and resolved bits stay put.
// RQ12: the timing sends ten demand-gated shift clocks per word, none more.
// RQ13: the finished word holds steady until the next clear pulse.
module sar_adc_sequencer
	import sar_adc_pkg::*;
(
	// clock, reset and enable
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// telemetry timing pins
	input wire logic data_demand,
	input wire logic clear_clock,
	input wire logic shift_clock,
	// comparator pin, high when analog_input_level exceeds ladder_trial_level
	input wire logic comp_high,
	// ladder switch drive, active low
	output logic [WORD_W-1:0] switch_drive_n,
	// result toward the multiplexer
	output logic [WORD_W-1:0] conversion_word,
	output logic word_ready
);

	pins_t pins_raw;
	pins_t pins_lvl;
	pins_t pins_rise;
	sar_state_t st_reg;
	sar_state_t st_next;
	logic step_req;
	logic step_taken;
	logic clear_taken;

	// one-hot mask for a bit position
	function automatic logic [WORD_W-1:0] bit_mask(input logic [TRIAL_W-1:0] idx);
		bit_mask = WORD_ONE << idx;
	endfunction : bit_mask

	// gather the external pins
	assign pins_raw.demand = data_demand;
	assign pins_raw.clear = clear_clock;
	assign pins_raw.shift = shift_clock;
	assign pins_raw.comp = comp_high;

	// pins cross into the core clock domain
	pin_sync u_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.pins_raw(pins_raw),
		.pins_lvl(pins_lvl)
	);

	// edges of the filtered pins
	pin_edge u_edge (
		.core_clk(core_clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.pins_lvl(pins_lvl),
		.pins_rise(pins_rise)
	);

	// shift clock counts only while data demand is high
	assign step_req = pins_rise.shift & pins_lvl.demand; // RQ12

	// a step or clear that actually changes state this cycle
	assign clear_taken = clk_en & pins_rise.clear;
	assign step_taken = clk_en & step_req & ~pins_rise.clear & (st_reg.phase == PH_CONVERT);

	// successive-approximation next state
	always_comb begin
		st_next = st_reg;
		if (pins_rise.clear) begin
			// clear wins over any step in the same cycle
			st_next.phase = PH_CONVERT; // RQ9
			st_next.trial = MSB_IDX; // RQ1
			st_next.drive = CLEAR_DRIVE; // RQ10
			st_next.ready = 1'b0;
		end else if (step_req && st_reg.phase == PH_CONVERT) begin
			if (!pins_lvl.comp) begin
				// ladder above input: release the tried switch
				st_next.drive = st_reg.drive | bit_mask(st_reg.trial); // RQ3 RQ8 RQ2
			end
			// input above ladder: tried switch stays closed, RQ4
			if (st_reg.trial == LSB_IDX) begin
				st_next.phase = PH_DONE; // RQ5
				st_next.ready = 1'b1;
			end else begin
				// close the next lower switch as the new trial
				st_next.drive = st_next.drive & ~bit_mask(st_reg.trial - TRIAL_ONE); // RQ11
				st_next.trial = st_reg.trial - TRIAL_ONE; // RQ1
			end
		end
		// word is always the complement of the drive
		st_next.word = ~st_next.drive; // RQ6 RQ7
	end

	// state register; done phase ignores further shifts
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= SAR_RESET;
		end else if (clk_en) begin
			st_reg <= st_next; // RQ13
		end
	end

	// outputs straight from the state register
	assign switch_drive_n = st_reg.drive;
	assign conversion_word = st_reg.word;
	assign word_ready = st_reg.ready;

	// steps counted since the last clear, for checking only
	logic [TRIAL_W-1:0] steps_seen;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			steps_seen <= TRIAL_ZERO;
		end else if (clear_taken) begin
			steps_seen <= TRIAL_ZERO;
		end else if (step_taken) begin
			steps_seen <= steps_seen + TRIAL_ONE;
		end
	end

	// checks on the sequencer
	default clocking cb @(posedge core_clk);
	endclocking

	default disable iff (!rstn);

	// a step where the input is below the ladder
	sequence s_step_low;
		step_taken && !pins_lvl.comp;
	endsequence

	// a step where the input is above the ladder
	sequence s_step_high;
		step_taken && pins_lvl.comp;
	endsequence

	// a step that leaves a lower bit to try
	sequence s_step_more;
		step_taken && st_reg.trial != LSB_IDX;
	endsequence

	// the step that decides the lsb
	sequence s_step_last;
		step_taken && st_reg.trial == LSB_IDX;
	endsequence

	// the first step after a clear, at the msb
	sequence s_step_first;
		step_taken && st_reg.trial == MSB_IDX;
	endsequence

	// clear loads the starting pattern
	property p_clear_start;
		clear_taken |=> switch_drive_n == CLEAR_DRIVE && conversion_word == CLEAR_WORD
			&& st_reg.trial == MSB_IDX && !word_ready;
	endproperty
	a_clear_start: assert property (p_clear_start) else $error("clear did not load start"); // RQ10

	// clear always moves the sequencer to conversion
	property p_clear_phase;
		clear_taken |=> st_reg.phase == PH_CONVERT;
	endproperty
	a_clear_phase: assert property (p_clear_phase) else $error("clear did not start convert"); // RQ9

	// input below ladder releases the tried switch
	property p_return_one;
		s_step_low |=> switch_drive_n[$past(st_reg.trial)] == 1'b1;
	endproperty
	a_return_one: assert property (p_return_one) else $error("tried bit not released"); // RQ3

	// input above ladder keeps the tried switch closed
	property p_keep_zero;
		s_step_high |=> switch_drive_n[$past(st_reg.trial)] == 1'b0;
	endproperty
	a_keep_zero: assert property (p_keep_zero) else $error("tried bit not kept"); // RQ4

	// a step moves the trial one bit down and closes that switch
	property p_next_trial;
		s_step_more |=> st_reg.trial == $past(st_reg.trial) - TRIAL_ONE
			&& switch_drive_n[st_reg.trial] == 1'b0;
	endproperty
	a_next_trial: assert property (p_next_trial) else $error("next trial not set"); // RQ1

	// resolved upper bits do not change on a step
	property p_upper_fixed;
		s_step_more |=> (switch_drive_n & ~((bit_mask($past(st_reg.trial)) << 1) - WORD_ONE))
			== ($past(switch_drive_n) & ~((bit_mask($past(st_reg.trial)) << 1) - WORD_ONE));
	endproperty
	a_upper_fixed: assert property (p_upper_fixed) else $error("resolved bit changed"); // RQ11

	// the lsb step completes the word
	property p_done;
		s_step_last |=> word_ready && st_reg.phase == PH_DONE;
	endproperty
	a_done: assert property (p_done) else $error("word not completed"); // RQ5

	// a completed word has seen exactly ten steps
	property p_ten_steps;
		$rose(word_ready) |-> steps_seen == STEP_COUNT;
	endproperty
	a_ten_steps: assert property (p_ten_steps) else $error("step count not ten"); // RQ7

	// word is the complement of the drive at all times
	property p_complement;
		conversion_word == ~switch_drive_n;
	endproperty
	a_complement: assert property (p_complement) else $error("word not complement"); // RQ6

	// completed word holds until a clear
	property p_hold;
		word_ready && !clear_taken |=> word_ready && $stable(conversion_word)
			&& $stable(switch_drive_n);
	endproperty
	a_hold: assert property (p_hold) else $error("word changed before clear"); // RQ13

	// extra shift clocks after completion have no effect
	property p_no_extra;
		st_reg.phase == PH_DONE && clk_en && step_req && !pins_rise.clear
			|=> $stable(switch_drive_n) [*2];
	endproperty
	a_no_extra: assert property (p_no_extra) else $error("extra clock moved drive"); // RQ12

	// the first step starts from a freshly cleared word
	property p_first_step;
		s_step_first |-> steps_seen == TRIAL_ZERO;
	endproperty
	a_first_step: assert property (p_first_step) else $error("first step not at msb"); // RQ1

	// while converting, the tried switch is closed
	property p_trial_closed;
		st_reg.phase == PH_CONVERT |-> switch_drive_n[st_reg.trial] == 1'b0;
	endproperty
	a_trial_closed: assert property (p_trial_closed) else $error("tried switch open"); // RQ1

	// while converting, switches below the trial are still open
	property p_lower_open;
		st_reg.phase == PH_CONVERT |-> (switch_drive_n & (bit_mask(st_reg.trial) - WORD_ONE))
			== (bit_mask(st_reg.trial) - WORD_ONE);
	endproperty
	a_lower_open: assert property (p_lower_open) else $error("untried switch closed"); // RQ10

	// idle after reset: nothing moves until a clear
	property p_idle_hold;
		st_reg.phase == PH_IDLE && !clear_taken |=> st_reg.phase == PH_IDLE
			&& $stable(switch_drive_n);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("idle sequencer moved"); // RQ9

	// shifts without data demand are refused
	property p_demand_gate;
		st_reg.phase == PH_CONVERT && clk_en && pins_rise.shift && !pins_lvl.demand
			&& !pins_rise.clear |=> $stable(switch_drive_n) && $stable(st_reg.trial);
	endproperty
	a_demand_gate: assert property (p_demand_gate) else $error("ungated shift stepped"); // RQ12

	// ready flags exactly the done phase
	property p_ready_phase;
		word_ready == (st_reg.phase == PH_DONE);
	endproperty
	a_ready_phase: assert property (p_ready_phase) else $error("ready out of step"); // RQ5

	// a frozen clock enable holds every output
	property p_freeze;
		!clk_en |=> $stable(switch_drive_n) && $stable(conversion_word) && $stable(word_ready);
	endproperty
	a_freeze: assert property (p_freeze) else $error("outputs moved while frozen"); // RQ11

	// the drive moves only on a step or a clear
	property p_drive_cause;
		$changed(switch_drive_n) |-> $past(step_taken) || $past(clear_taken);
	endproperty
	a_drive_cause: assert property (p_drive_cause) else $error("drive moved unprompted"); // RQ11

	// ready drops only through a clear
	property p_ready_fall;
		$fell(word_ready) |-> $past(clear_taken);
	endproperty
	a_ready_fall: assert property (p_ready_fall) else $error("ready dropped early"); // RQ13

	// never more than ten steps per word
	property p_steps_bound;
		steps_seen <= STEP_COUNT;
	endproperty
	a_steps_bound: assert property (p_steps_bound) else $error("too many steps"); // RQ12

	// the trial index stays inside the word
	property p_trial_range;
		st_reg.trial <= MSB_IDX;
	endproperty
	a_trial_range: assert property (p_trial_range) else $error("trial out of range"); // RQ7

endmodule : sar_adc_sequencer
`default_nettype wire

/* File: verification/ladder_comparator.sv */
`timescale 1ns/100ps
`default_nettype none
module ladder_comparator
	import sar_adc_pkg::*;
(
	// analog side stand-ins
	input wire logic [WORD_W-1:0] analog_input_level,
	input wire logic [WORD_W-1:0] switch_drive_n,
	// comparator result
	output logic comp_high
);
	// closed switches set the ladder code, drive is active low
	logic [WORD_W-1:0] ladder_trial_level;
	assign ladder_trial_level = ~switch_drive_n;
	// high only while the input stands above the ladder
	assign comp_high = (analog_input_level > ladder_trial_level);
endmodule : ladder_comparator
`default_nettype wire

/* File: verification/sar_adc_sequencer_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module sar_adc_sequencer_bench
	import sar_adc_pkg::*;
;
	// stimulus and observed ports
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic clk_en = 1'b1;
	logic data_demand = 1'b0;
	logic clear_clock = 1'b0;
	logic shift_clock = 1'b0;
	logic [WORD_W-1:0] analog_input_level = 10'h000;
	wire logic comp_high;
	logic [WORD_W-1:0] switch_drive_n;
	logic [WORD_W-1:0] conversion_word;
	logic word_ready;
	int error_cnt = 0;
	int comparisons = 0;
	int cycle_cnt = 0;

	sar_adc_sequencer sar_adc_sequencer_i (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
		.data_demand(data_demand), .clear_clock(clear_clock), .shift_clock(shift_clock),
		.comp_high(comp_high), .switch_drive_n(switch_drive_n),
		.conversion_word(conversion_word), .word_ready(word_ready));
	ladder_comparator ladder_comparator_i (.analog_input_level(analog_input_level),
		.switch_drive_n(switch_drive_n), .comp_high(comp_high));

	// clock and hang guard
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycle_cnt++;
		if (cycle_cnt == 8000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#5;
	endtask : cyc

	// one pin pulse, long enough for the filter on both levels
	task automatic pulse(input logic is_clear);
		if (is_clear) clear_clock = 1'b1;
		else shift_clock = 1'b1;
		cyc(8);
		clear_clock = 1'b0;
		shift_clock = 1'b0;
		cyc(8);
	endtask : pulse

	// full word, optionally cut short by a clear before step abort_at
	task automatic convert(input logic [WORD_W-1:0] level, input int abort_at);
		logic [WORD_W-1:0] res;
		logic [WORD_W-1:0] trial;
		logic [WORD_W-1:0] exp;
		int b;
		analog_input_level = level;
		data_demand = 1'b1;
		cyc(8);
		pulse(1'b1);
		check(conversion_word, CLEAR_WORD);
		check(switch_drive_n, CLEAR_DRIVE);
		check({9'h000, word_ready}, 10'h000);
		data_demand = 1'b0;
		cyc(8);
		pulse(1'b0);
		data_demand = 1'b1;
		cyc(8);
		check(conversion_word, CLEAR_WORD);
		res = 10'h000;
		for (int k = 1; k <= 10; k++) begin
			if (k == abort_at) begin
				pulse(1'b1);
				check(conversion_word, CLEAR_WORD);
				data_demand = 1'b0;
				cyc(8);
				return;
			end
			pulse(1'b0);
			b = 10 - k;
			trial = res | (10'h001 << b);
			if (level > trial) res = trial;
			exp = (k < 10) ? (res | (10'h001 << (b - 1))) : res;
			check(conversion_word, exp);
			check(~switch_drive_n, exp);
		end
		check({9'h000, word_ready}, 10'h001);
		pulse(1'b0);
		check(conversion_word, res);
		data_demand = 1'b0;
		cyc(8);
	endtask : convert

	task automatic test_reset();
		check(conversion_word, CLEAR_WORD);
		check(switch_drive_n, CLEAR_DRIVE);
	endtask : test_reset

	// a pulse with the clock enable low must leave no trace
	task automatic test_freeze();
		data_demand = 1'b1;
		pulse(1'b1);
		clk_en = 1'b0;
		pulse(1'b0);
		clk_en = 1'b1;
		cyc(8);
		check(conversion_word, CLEAR_WORD);
		data_demand = 1'b0;
		cyc(8);
	endtask : test_freeze

	task automatic test_levels();
		logic [WORD_W-1:0] lv [6];
		lv = '{10'h000, 10'h3FF, 10'h200, 10'h1FF, 10'h155, 10'h2AA};
		foreach (lv[i]) convert(lv[i], 0);
	endtask : test_levels

	// clear mid-word, then a reset in mid-run
	task automatic test_abort();
		convert(10'h2AA, 6);
		data_demand = 1'b1;
		pulse(1'b1);
		pulse(1'b0);
		check(conversion_word, CLEAR_WORD | (CLEAR_WORD >> 1));
		rstn = 1'b0;
		cyc(1);
		check(conversion_word, CLEAR_WORD);
		rstn = 1'b1;
		cyc(8);
		pulse(1'b0);
		check(conversion_word, CLEAR_WORD);
		data_demand = 1'b0;
		cyc(2);
	endtask : test_abort

	task automatic wrap_up();
		if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	// main sequence
	initial begin
		cyc(3);
		rstn = 1'b1;
		cyc(2);
		test_reset();
		test_freeze();
		test_levels();
		test_abort();
		wrap_up();
	end
endmodule : sar_adc_sequencer_bench
`default_nettype wire
